// ### bcw_defines.svh
// Constants for the bit-clear, watchdog-clear and complement execute slice
`ifndef BCW_DEFINES_SVH
`define BCW_DEFINES_SVH
`define BCW_DATA_W 8
`define BCW_BIT_SEL_W 3
`define BCW_ADDR_W 8
`define BCW_FLAG_CLEAR 1'b0
`endif

// ### bcw_pkg.sv
// Types for the bit-clear, watchdog-clear and complement execute slice
`include "bcw_defines.svh"
package bcw_pkg;
	// Operation codes handed over by the instruction decoder
	typedef enum logic [2:0] {
		BCW_OP_NONE = 3'h0,
		BCW_OP_BIT_CLEAR = 3'h1,
		BCW_OP_WDT_CLEAR = 3'h2,
		BCW_OP_WDT_PRE1 = 3'h3,
		BCW_OP_WDT_PRE2 = 3'h4,
		BCW_OP_COMPLEMENT = 3'h5
	} bcw_op_t;
	// Request from the decoder
	typedef struct packed {
		bcw_op_t op;
		logic [`BCW_ADDR_W-1:0] addr;
		logic [`BCW_BIT_SEL_W-1:0] bit_sel;
	} bcw_req_t;
	// Write-back to data memory
	typedef struct packed {
		logic en;
		logic [`BCW_ADDR_W-1:0] addr;
		logic [`BCW_DATA_W-1:0] data;
	} bcw_wr_t;
	// Which pre-clear form ran last
	typedef enum logic [2:0] {
		BCW_PRE_NONE = 3'h1,
		BCW_PRE_FIRST = 3'h2,
		BCW_PRE_SECOND = 3'h4
	} bcw_pre_t;
endpackage

// ### bcw_exec.sv
// Execute slice: bit clear, watchdog clear/pre-clear, complement
`timescale 1ns/1ps
`include "bcw_defines.svh"
module bcw_exec (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire bcw_pkg::bcw_req_t req_i,
	input wire logic [`BCW_DATA_W-1:0] rd_data_i,
	input wire logic timeout_flag_set_i,
	input wire logic powerdown_flag_set_i,
	output bcw_pkg::bcw_wr_t wr_o,
	output logic watchdog_clear_o,
	output logic timeout_flag_o,
	output logic powerdown_flag_o,
	output logic zero_flag_o
);
	////////////////////////////////////////////////////////////////////
	// Decode; memory read data is same-cycle combinational from the
	// address in req_i, so no synchroniser is needed here
	// Op match shared by every decode wire below
	function automatic logic op_is(input bcw_pkg::bcw_op_t op,
			input bcw_pkg::bcw_op_t code);
		return op == code;
	endfunction
	wire logic is_bclr = op_is(req_i.op, bcw_pkg::BCW_OP_BIT_CLEAR);
	wire logic is_wclr = op_is(req_i.op, bcw_pkg::BCW_OP_WDT_CLEAR);
	wire logic is_pre1 = op_is(req_i.op, bcw_pkg::BCW_OP_WDT_PRE1);
	wire logic is_pre2 = op_is(req_i.op, bcw_pkg::BCW_OP_WDT_PRE2);
	wire logic is_cpl = op_is(req_i.op, bcw_pkg::BCW_OP_COMPLEMENT);
	bcw_pkg::bcw_pre_t last_pre;
	bcw_pkg::bcw_pre_t next_last_pre;
	// Pre-clear only counts when the other form ran last; the tracker
	// starts at none, so a lone form after reset cannot feed the dog
	wire logic pre1_fire = is_pre1
		&& (last_pre == bcw_pkg::BCW_PRE_SECOND);
	wire logic pre2_fire = is_pre2
		&& (last_pre == bcw_pkg::BCW_PRE_FIRST);
	wire logic pre_fire = pre1_fire || pre2_fire;
	wire logic next_wdt_clr = is_wclr || pre_fire;
	// Per-bit data path: invert for complement, drop only the selected
	// bit for bit clear; other ops compute a byte nobody writes
	wire logic [`BCW_DATA_W-1:0] next_data;
	for (genvar g = 0; g < `BCW_DATA_W; g++) begin : g_bit
		wire logic hit = (req_i.bit_sel == `BCW_BIT_SEL_W'(g));
		assign next_data[g] = is_cpl ? ~rd_data_i[g]
			: (rd_data_i[g] && !hit);
	end
	// Zero test on the value that will be stored, not on the read
	wire logic next_zero = (next_data == '0);
	////////////////////////////////////////////////////////////////////
	// Pre-clear tracker; plain clear leaves the pairing untouched
	always_comb begin
		unique case (1'b1)
			is_pre1: next_last_pre = bcw_pkg::BCW_PRE_FIRST;
			is_pre2: next_last_pre = bcw_pkg::BCW_PRE_SECOND;
			default: next_last_pre = last_pre;
		endcase
	end
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			last_pre <= bcw_pkg::BCW_PRE_NONE;
		end else if (clk_en_i) begin
			last_pre <= next_last_pre;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Write-back and watchdog pulse, registered
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			wr_o <= '0;
			watchdog_clear_o <= 1'b0;
		end else if (clk_en_i) begin
			wr_o.en <= is_bclr || is_cpl;
			wr_o.addr <= req_i.addr;
			wr_o.data <= next_data;
			watchdog_clear_o <= next_wdt_clr;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Status flags; a set from the watchdog or sleep logic wins over a
	// clear in the same cycle so the event is never lost
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			timeout_flag_o <= 1'b0;
			powerdown_flag_o <= 1'b0;
			zero_flag_o <= 1'b0;
		end else if (clk_en_i) begin
			if (timeout_flag_set_i) begin
				timeout_flag_o <= 1'b1;
			end else if (next_wdt_clr) begin
				timeout_flag_o <= `BCW_FLAG_CLEAR;
			end
			if (powerdown_flag_set_i) begin
				powerdown_flag_o <= 1'b1;
			end else if (next_wdt_clr) begin
				powerdown_flag_o <= `BCW_FLAG_CLEAR;
			end
			if (is_cpl) begin
				zero_flag_o <= next_zero;
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// Checks; each looks one edge after the request is taken
	// Bit clear: selected bit low, the rest and all flags untouched
	chk_bclr_bit_zero: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_bclr |=> wr_o.en
		&& wr_o.data[$past(req_i.bit_sel)] == 1'b0)
		else $error("bit clear left bit set");
	chk_bclr_others_kept: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_bclr |=>
		(wr_o.data | (`BCW_DATA_W'(1) << $past(req_i.bit_sel)))
		== ($past(rd_data_i) | (`BCW_DATA_W'(1) << $past(req_i.bit_sel))))
		else $error("bit clear changed other bits");
	chk_bclr_addr: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_bclr |=>
		wr_o.addr == $past(req_i.addr))
		else $error("bit clear wrote wrong address");
	chk_bclr_no_zflag: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_bclr |=>
		$stable(zero_flag_o))
		else $error("bit clear touched zero flag");
	chk_bclr_no_wflags: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_bclr && !timeout_flag_set_i
		&& !powerdown_flag_set_i |=> !watchdog_clear_o
		&& $stable(timeout_flag_o) && $stable(powerdown_flag_o))
		else $error("bit clear touched watchdog flags");
	// Watchdog clears and the pairing of the two pre-clear forms
	chk_wclr_clears: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_wclr && !timeout_flag_set_i
		&& !powerdown_flag_set_i |=> watchdog_clear_o && !timeout_flag_o
		&& !powerdown_flag_o)
		else $error("watchdog clear failed");
	chk_wclr_keeps_pair: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_wclr |=>
		last_pre == $past(last_pre))
		else $error("plain clear changed pairing");
	chk_pre_pair_fire: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_pre1 ##1 clk_en_i && is_pre2
		|=> watchdog_clear_o)
		else $error("second pre-clear after first did not fire");
	chk_pre2_then_1: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_pre2 ##1 clk_en_i && is_pre1
		|=> watchdog_clear_o)
		else $error("first pre-clear after second did not fire");
	chk_pre_repeat: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_pre1 ##1 clk_en_i && is_pre1
		|=> !watchdog_clear_o)
		else $error("repeated first pre-clear fired");
	chk_pre2_repeat: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_pre2 ##1 clk_en_i && is_pre2
		|=> !watchdog_clear_o)
		else $error("repeated second pre-clear fired");
	chk_pre2_clears_flags: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_pre2 && last_pre == bcw_pkg::BCW_PRE_FIRST
		&& !timeout_flag_set_i && !powerdown_flag_set_i
		|=> watchdog_clear_o && !timeout_flag_o && !powerdown_flag_o)
		else $error("paired second pre-clear left flags");
	chk_pre1_clears_flags: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_pre1 && last_pre == bcw_pkg::BCW_PRE_SECOND
		&& !timeout_flag_set_i && !powerdown_flag_set_i
		|=> watchdog_clear_o && !timeout_flag_o && !powerdown_flag_o)
		else $error("paired first pre-clear left flags");
	// Complement: inverted byte written back, zero flag follows it
	chk_cpl_data: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_cpl |=> wr_o.en
		&& wr_o.data == ~$past(rd_data_i))
		else $error("complement data wrong");
	chk_cpl_addr: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_cpl |=>
		wr_o.addr == $past(req_i.addr))
		else $error("complement wrote wrong address");
	chk_cpl_zero: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_cpl |=>
		zero_flag_o == (~$past(rd_data_i) == '0))
		else $error("zero flag mismatch after complement");
	chk_cpl_no_wflags: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && is_cpl && !timeout_flag_set_i
		&& !powerdown_flag_set_i |=> !watchdog_clear_o
		&& $stable(timeout_flag_o) && $stable(powerdown_flag_o))
		else $error("complement touched watchdog flags");
	// Set requests beat clears, idle does nothing, enable low freezes
	chk_set_wins: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && (timeout_flag_set_i || powerdown_flag_set_i) |=>
		(!$past(timeout_flag_set_i) || timeout_flag_o)
		&& (!$past(powerdown_flag_set_i) || powerdown_flag_o))
		else $error("flag set request lost");
	chk_none_idle: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		clk_en_i && req_i.op == bcw_pkg::BCW_OP_NONE |=>
		!wr_o.en && !watchdog_clear_o)
		else $error("idle op produced a write or clear");
	chk_freeze_all: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		!clk_en_i |=> $stable(wr_o) && $stable(watchdog_clear_o)
		&& $stable(timeout_flag_o) && $stable(powerdown_flag_o)
		&& $stable(zero_flag_o) && $stable(last_pre))
		else $error("state moved while enable low");
endmodule // bcw_exec

// ### bcw_exec_tb.sv
// Self-checking bench for the bit-clear, watchdog-clear and complement slice
`timescale 1ns/1ps
module bcw_exec_tb;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic clk_en_i = 1'b1;
	bcw_pkg::bcw_req_t req_i = '0;
	logic [7:0] rd_data_i = 8'h00;
	logic to_set = 1'b0;
	logic pd_set = 1'b0;
	bcw_pkg::bcw_wr_t wr_o;
	logic wdc, to_f, pd_f, z_f;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	////////////////////////////////////////////////////////////////////////
	// Clock, and a cycle ceiling so a hang still ends in the verdict
	always #50 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_errors++;
			$display("[FAIL] cycle_limit expected %0d seen %0d", 2000, cyc);
			finish_test();
		end
	end
	bcw_exec u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i), .req_i(req_i), .rd_data_i(rd_data_i),
		.timeout_flag_set_i(to_set), .powerdown_flag_set_i(pd_set),
		.wr_o(wr_o), .watchdog_clear_o(wdc), .timeout_flag_o(to_f),
		.powerdown_flag_o(pd_f), .zero_flag_o(z_f));
	////////////////////////////////////////////////////////////////////////
	// Case equality so an unknown output never passes
	task automatic chk(input string nm, input logic [23:0] e,
			input logic [23:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One request for one enabled edge; stale read data inverted after
	task automatic run(input bcw_pkg::bcw_op_t o, input logic [7:0] a,
			input logic [2:0] b, input logic [7:0] d);
		@(posedge clock_i);
		req_i <= '{op: o, addr: a, bit_sel: b};
		rd_data_i <= d;
		@(posedge clock_i);
		req_i.op <= bcw_pkg::BCW_OP_NONE;
		rd_data_i <= ~d;
		#1;
	endtask
	task automatic set_flags;
		@(posedge clock_i);
		to_set <= 1'b1;
		pd_set <= 1'b1;
		@(posedge clock_i);
		to_set <= 1'b0;
		pd_set <= 1'b0;
		#1;
		chk("flags_set", 2'b11, {to_f, pd_f});
	endtask
	////////////////////////////////////////////////////////////////////////
	// Zero result and all-ones result both exercised
	task automatic t_comp;
		logic [7:0] d [3] = '{8'h5a, 8'h00, 8'hff};
		foreach (d[k]) begin
			run(bcw_pkg::BCW_OP_COMPLEMENT, 8'h10, 3'h0, d[k]);
			chk("cpl_wr", {1'b1, 8'h10, ~d[k]}, wr_o);
			chk("cpl_zero", (~d[k] == 8'h00), z_f);
		end
		$display("complement test done");
	endtask
	// Every bit position; flags must not move
	task automatic t_bitclr;
		set_flags();
		for (int i = 0; i < 8; i++) begin
			run(bcw_pkg::BCW_OP_BIT_CLEAR, 8'(8'h40 + i), 3'(i), 8'hff);
			chk("bclr_wr", {1'b1, 8'(8'h40 + i), ~(8'h01 << i)}, wr_o);
			chk("bclr_flags", 3'b111, {to_f, pd_f, z_f});
		end
		$display("bit clear test done");
	endtask
	// Plain clear, then pairing of the pre-clear forms from reset state
	task automatic t_wdt;
		set_flags();
		run(bcw_pkg::BCW_OP_WDT_CLEAR, 8'h00, 3'h0, 8'h00);
		chk("wdt_clr", 3'b100, {wdc, to_f, pd_f});
		set_flags();
		run(bcw_pkg::BCW_OP_WDT_PRE1, 8'h00, 3'h0, 8'h00);
		chk("pre1_first", 3'b011, {wdc, to_f, pd_f});
		run(bcw_pkg::BCW_OP_WDT_PRE1, 8'h00, 3'h0, 8'h00);
		chk("pre1_again", 3'b011, {wdc, to_f, pd_f});
		run(bcw_pkg::BCW_OP_WDT_PRE2, 8'h00, 3'h0, 8'h00);
		chk("pre2_pair", 3'b100, {wdc, to_f, pd_f});
		set_flags();
		run(bcw_pkg::BCW_OP_WDT_PRE1, 8'h00, 3'h0, 8'h00);
		chk("pre1_pair", 3'b100, {wdc, to_f, pd_f});
		set_flags();
		run(bcw_pkg::BCW_OP_WDT_PRE1, 8'h00, 3'h0, 8'h00);
		chk("pre1_rep", 3'b011, {wdc, to_f, pd_f});
		$display("watchdog test done");
	endtask
	// Enable low must hold the last result while new ops are offered
	task automatic t_hold;
		@(posedge clock_i);
		req_i <= '{op: bcw_pkg::BCW_OP_COMPLEMENT, addr: 8'h22,
			bit_sel: 3'h0};
		rd_data_i <= 8'hff;
		@(posedge clock_i);
		clk_en_i <= 1'b0;
		req_i <= '{op: bcw_pkg::BCW_OP_COMPLEMENT, addr: 8'h33,
			bit_sel: 3'h0};
		rd_data_i <= 8'h0f;
		repeat (3) @(posedge clock_i);
		#1;
		chk("hold_wr", {1'b1, 8'h22, 8'h00}, wr_o);
		chk("hold_zero", 1'b1, z_f);
		@(posedge clock_i);
		clk_en_i <= 1'b1;
		req_i.op <= bcw_pkg::BCW_OP_NONE;
		@(posedge clock_i);
		#1;
		chk("hold_done", 1'b0, wr_o.en);
		$display("enable hold test done");
	endtask
	// Set beats clear; idle op; plain clear keeps pre-clear pairing
	task automatic t_pair_gap;
		@(posedge clock_i);
		req_i <= '{op: bcw_pkg::BCW_OP_WDT_CLEAR, addr: 8'h00,
			bit_sel: 3'h0};
		to_set <= 1'b1;
		@(posedge clock_i);
		req_i.op <= bcw_pkg::BCW_OP_NONE;
		to_set <= 1'b0;
		#1;
		chk("set_wins", 3'b110, {wdc, to_f, pd_f});
		run(bcw_pkg::BCW_OP_NONE, 8'h00, 3'h0, 8'h00);
		chk("none_idle", 2'b00, {wr_o.en, wdc});
		set_flags();
		run(bcw_pkg::BCW_OP_WDT_PRE2, 8'h00, 3'h0, 8'h00);
		chk("pre2_gap", 3'b100, {wdc, to_f, pd_f});
		$display("pairing gap test done");
	endtask
	// Reset in mid-run forgets which pre-clear form ran last
	task automatic t_reset_mid;
		@(posedge clock_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1;
		chk("reset_mid", 21'h0, {wr_o, wdc, to_f, pd_f, z_f});
		set_flags();
		run(bcw_pkg::BCW_OP_WDT_PRE1, 8'h00, 3'h0, 8'h00);
		chk("pre1_after_rst", 3'b011, {wdc, to_f, pd_f});
		$display("mid-run reset test done");
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Reset for 20 cycles, then the scenarios in order
	initial begin
		repeat (20) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1;
		chk("reset_out", 21'h0, {wr_o, wdc, to_f, pd_f, z_f});
		t_wdt();
		t_comp();
		t_bitclr();
		t_hold();
		t_pair_gap();
		t_reset_mid();
		finish_test();
	end
endmodule // bcw_exec_tb
